/* File: include/pfs_pkg.sv */
// package of constants for the port-0 pin function select block
package pfs_pkg;
	// ============================================================
	// register map (printed offsets are not word aligned: index * 4)
	localparam logic [15:0] PFS_PIN1_IDX  = 16'hA051;
	localparam logic [15:0] PFS_PIN2_IDX  = 16'hA052;
	localparam logic [15:0] PFS_PIN3_IDX  = 16'hA053;
	localparam logic [15:0] PFS_PAD_IDX   = 16'hA060;
	localparam int          PFS_ADDR_W    = 18;
	localparam logic [7:0]  PFS_RESET_VAL = 8'h00;
	// ============================================================
	// field positions of a function select register
	localparam int PFS_B_TOUCH = 7;
	localparam int PFS_B_HI    = 6;
	localparam int PFS_B_MID   = 5;
	localparam int PFS_B_CAP   = 4;
	localparam int PFS_B_SPI   = 3;
	localparam int PFS_B_IRQB  = 2;
	localparam int PFS_B_IRQA  = 1;
	localparam int PFS_B_GPIO  = 0;
	// ============================================================
	// pad config register: analog_connect of pins 1 and 3
	localparam int PFS_B_AN1 = 0;
	localparam int PFS_B_AN3 = 1;
	localparam logic [1:0] PFS_PAD_MASK = 2'h3;
	// ============================================================
	// pin-3 output driver owner, in priority order
	typedef enum logic [2:0]
	{
		PFS_OWN_NONE,
		PFS_OWN_LIN_TX,
		PFS_OWN_STD_TX,
		PFS_OWN_CAP,
		PFS_OWN_GPIO
	} pfs_owner_t;
endpackage

/* File: design/pfs_sync2.sv */
// two flip-flop synchroniser for pad input levels
`timescale 1ns/1ps
module pfs_sync2 #(
	parameter int WIDTH = 3
)
(
	input  wire logic             clk_in, // system clock
	input  wire logic             rst_in, // sync reset, high
	input  wire logic [WIDTH-1:0] d_in,   // async level
	output logic      [WIDTH-1:0] q_out   // synchronised level
);
	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} pfs_sync_t;
	pfs_sync_t st_reg;
	pfs_sync_t st_next;

	always_comb
	begin
		st_next.s1 = d_in;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign q_out = st_reg.s2;
endmodule

/* File: design/pfs_pin_cfg.sv */
// one function select register with bus write and synchronous reset to PFS_RESET_VAL
`timescale 1ns/1ps
module pfs_pin_cfg
	import pfs_pkg::*;
(
	input  wire logic       clk_in,   // system clock
	input  wire logic       rst_in,   // sync reset, high
	input  wire logic       wr_in,    // write strobe, one cycle
	input  wire logic [7:0] wdata_in, // write data
	output logic      [7:0] cfg_out   // stored value
);
	typedef struct packed
	{
		logic [7:0] cfg;
	} pfs_cfg_t;
	pfs_cfg_t st_reg;
	pfs_cfg_t st_next;

	always_comb
	begin
		st_next = st_reg;
		if (wr_in)
			st_next.cfg = wdata_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			st_reg.cfg <= PFS_RESET_VAL;
		else
			st_reg <= st_next;
	end

	assign cfg_out = st_reg.cfg;

	// ============================================================
	// checks
	write_stored_a: assert property (@(posedge clk_in)
		disable iff (rst_in) wr_in |=> cfg_out == $past(wdata_in))
		else $error("config write not stored");
	hold_value_a: assert property (@(posedge clk_in)
		disable iff (rst_in) !wr_in |=> $stable(cfg_out))
		else $error("config changed without write");
	reset_zero_a: assert property (@(posedge clk_in)
		rst_in |=> cfg_out == PFS_RESET_VAL)
		else $error("config not cleared by reset");
endmodule

/* File: design/pfs_top.sv */
// function select mux for port-0 pins 1 to 3 with Avalon-MM registers
// ============================================================
// How it works
// - three 8-bit registers, reset zero
// - pins 1,3 bit 7 touch, needs analog
// - pin 3 bit 7 touch channel 3
// - pin 1 bit 6 i2c master clock
// - pin 1 bit 5 i2c slave b clock
// - pin 1 bit 4 capcomp channel 1
// - pin 1 bit 3 spi clock
// - bit 2 feeds pin interrupt b
// - bit 1 feeds pin interrupt a
// - interrupts OR all selected pins
// - bit 0 plain io, default off
// - pin 2 bit 6 lin uart rx
// - pin 2 bit 5 std uart rx
// - pin 2 bit 4 capcomp channel 2
// - pin 2 bit 3 spi mosi
// - pin 3 bit 6 lin uart tx
// - pin 3 bit 5 std uart tx
// - pin 3 bit 4 capcomp channel 3
// - pin 3 bit 3 spi slave select
// - analog_connect links pin to analog
`timescale 1ns/1ps
module pfs_top
	import pfs_pkg::*;
(
	input  wire logic                  clk_in,            // 200 MHz clock
	input  wire logic                  rst_in,            // sync reset
	// avalon-mm slave
	input  wire logic [pfs_pkg::PFS_ADDR_W-1:0] address_in, // byte address
	input  wire logic                  read_in,           // read request
	input  wire logic                  write_in,          // write request
	input  wire logic [31:0]           writedata_in,      // write data
	input  wire logic [3:0]            byteenable_in,     // byte lanes
	output logic      [31:0]           readdata_out,      // read data
	output logic                       waitrequest_out,   // stall
	output logic      [1:0]            response_out,      // 00 ok 10 err
	// pad side
	input  wire logic [2:0]            pad_in,            // pins 3..1
	output logic      [2:0]            pad_out,           // drive level
	output logic      [2:0]            pad_oe_out,        // drive enable
	output logic      [2:0]            analog_connect_out, // pad to analog
	// peripheral side
	input  wire logic                  i2c_master_scl_in,  // 0 pulls low
	input  wire logic                  i2c_slave_b_scl_in, // 0 pulls low
	output logic                       i2c_master_scl_out, // pin level
	output logic                       i2c_slave_b_scl_out, // pin level
	input  wire logic [2:0]            capcomp_o_in,       // ch 3..1 out
	input  wire logic [2:0]            capcomp_oe_in,      // ch 3..1 oe
	output logic      [2:0]            capcomp_i_out,      // ch 3..1 in
	input  wire logic                  spi_clk_o_in,       // master sck
	input  wire logic                  spi_clk_oe_in,      // master mode
	output logic                       spi_clk_out,        // sck in
	input  wire logic                  spi_mosi_o_in,      // master mosi
	input  wire logic                  spi_mosi_oe_in,     // master mode
	output logic                       spi_mosi_out,       // mosi in
	output logic                       spi_ss_out,         // slave select
	output logic                       lin_uart_rx_out,    // lin rx
	output logic                       std_uart_rx_out,    // std rx
	input  wire logic                  lin_uart_tx_in,     // lin tx
	input  wire logic                  std_uart_tx_in,     // std tx
	input  wire logic [2:0]            gpio_o_in,          // gpio drive
	input  wire logic [2:0]            gpio_oe_in,         // gpio oe
	output logic      [2:0]            gpio_i_out,         // gpio level
	output logic      [2:0]            touch_en_out,       // touch ch 3..1
	output logic                       pin_irq_a_out,      // irq a level
	output logic                       pin_irq_b_out       // irq b level
);
	// ============================================================
	// state
	typedef struct packed
	{
		logic [31:0] rdata;
		logic        ack;
		logic [1:0]  resp;
		logic [1:0]  pad_cfg;
		logic [2:0]  pad_o;
		logic [2:0]  pad_oe;
		logic [2:0]  an;
		logic        m_scl;
		logic        s_scl;
		logic [2:0]  cap_i;
		logic        sck;
		logic        mosi;
		logic        ss;
		logic        lin_rx;
		logic        std_rx;
		logic [2:0]  gpio_i;
		logic [2:0]  touch;
		logic        irq_a;
		logic        irq_b;
	} pfs_state_t;
	pfs_state_t st_reg;
	pfs_state_t st_next;

	logic [7:0]  cfg1;
	logic [7:0]  cfg2;
	logic [7:0]  cfg3;
	logic [2:0]  pin_lvl;
	logic [15:0] idx;
	logic        aligned;
	logic        req;
	logic        wr_ok;
	logic [2:0]  cfg_wr;
	pfs_owner_t  owner3;

	// ============================================================
	// bus decode: one wait cycle, answer on the second
	assign idx     = address_in[PFS_ADDR_W-1:2];
	assign aligned = address_in[1:0] == 2'h0;
	assign req     = (read_in | write_in) & !st_reg.ack;
	assign wr_ok   = req & write_in & aligned & byteenable_in[0];
	assign cfg_wr[0] = wr_ok & (idx == PFS_PIN1_IDX);
	assign cfg_wr[1] = wr_ok & (idx == PFS_PIN2_IDX);
	assign cfg_wr[2] = wr_ok & (idx == PFS_PIN3_IDX);

	pfs_pin_cfg u_cfg1
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.wr_in    (cfg_wr[0]),
		.wdata_in (writedata_in[7:0]),
		.cfg_out  (cfg1)
	);
	pfs_pin_cfg u_cfg2
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.wr_in    (cfg_wr[1]),
		.wdata_in (writedata_in[7:0]),
		.cfg_out  (cfg2)
	);
	pfs_pin_cfg u_cfg3
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.wr_in    (cfg_wr[2]),
		.wdata_in (writedata_in[7:0]),
		.cfg_out  (cfg3)
	);

	pfs_sync2 #(.WIDTH(3)) u_sync
	(
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   (pad_in),
		.q_out  (pin_lvl)
	);

	// pin 3 driver: uart tx first, then capcomp, then gpio
	always_comb
	begin
		owner3 = PFS_OWN_NONE;
		if (cfg3[PFS_B_HI])
			owner3 = PFS_OWN_LIN_TX;
		else if (cfg3[PFS_B_MID])
			owner3 = PFS_OWN_STD_TX;
		else if (cfg3[PFS_B_CAP] & capcomp_oe_in[2])
			owner3 = PFS_OWN_CAP;
		else if (cfg3[PFS_B_GPIO] & gpio_oe_in[2])
			owner3 = PFS_OWN_GPIO;
	end

	always_comb
	begin
		st_next = st_reg;
		// ------------------------------------------------ bus
		st_next.ack = req;
		if (req)
		begin
			st_next.rdata = 32'h0000_0000;
			st_next.resp  = 2'h0;
			if (!aligned)
				st_next.resp = 2'h2;
			else if (idx == PFS_PIN1_IDX)
				st_next.rdata[7:0] = cfg1;
			else if (idx == PFS_PIN2_IDX)
				st_next.rdata[7:0] = cfg2;
			else if (idx == PFS_PIN3_IDX)
				st_next.rdata[7:0] = cfg3;
			else if (idx == PFS_PAD_IDX)
			begin
				st_next.rdata[1:0] = st_reg.pad_cfg;
				if (write_in & byteenable_in[0])
					st_next.pad_cfg = writedata_in[1:0] & PFS_PAD_MASK;
			end
			else
				st_next.resp = 2'h2;
		end
		else
			st_next.rdata = 32'h0000_0000;
		// ------------------------------------------------ analog
		st_next.an = {st_reg.pad_cfg[PFS_B_AN3], 1'b0,
			st_reg.pad_cfg[PFS_B_AN1]};
		// touch on pins 1 and 3 needs both its select and analog_connect; pin 2 needs only its select
		st_next.touch[0] = cfg1[PFS_B_TOUCH] & st_reg.pad_cfg[PFS_B_AN1];
		st_next.touch[1] = cfg2[PFS_B_TOUCH];
		st_next.touch[2] = cfg3[PFS_B_TOUCH] & st_reg.pad_cfg[PFS_B_AN3];
		// ------------------------------------------------ pin 1
		// open drain scl: i2c owners win, then capcomp, spi, gpio
		st_next.pad_o[0]  = 1'b0;
		st_next.pad_oe[0] = 1'b0;
		if (cfg1[PFS_B_HI] | cfg1[PFS_B_MID])
			st_next.pad_oe[0] = (cfg1[PFS_B_HI] & !i2c_master_scl_in) |
				(cfg1[PFS_B_MID] & !i2c_slave_b_scl_in);
		else if (cfg1[PFS_B_CAP])
		begin
			st_next.pad_o[0]  = capcomp_o_in[0];
			st_next.pad_oe[0] = capcomp_oe_in[0];
		end
		else if (cfg1[PFS_B_SPI])
		begin
			st_next.pad_o[0]  = spi_clk_o_in;
			st_next.pad_oe[0] = spi_clk_oe_in;
		end
		else if (cfg1[PFS_B_GPIO])
		begin
			st_next.pad_o[0]  = gpio_o_in[0];
			st_next.pad_oe[0] = gpio_oe_in[0];
		end
		st_next.m_scl    = cfg1[PFS_B_HI] ? pin_lvl[0] : 1'b1;
		st_next.s_scl    = cfg1[PFS_B_MID] ? pin_lvl[0] : 1'b1;
		st_next.cap_i[0] = cfg1[PFS_B_CAP] & pin_lvl[0];
		st_next.sck      = cfg1[PFS_B_SPI] & pin_lvl[0];
		// ------------------------------------------------ pin 2
		st_next.pad_o[1]  = 1'b0;
		st_next.pad_oe[1] = 1'b0;
		if (cfg2[PFS_B_CAP])
		begin
			st_next.pad_o[1]  = capcomp_o_in[1];
			st_next.pad_oe[1] = capcomp_oe_in[1];
		end
		else if (cfg2[PFS_B_SPI])
		begin
			st_next.pad_o[1]  = spi_mosi_o_in;
			st_next.pad_oe[1] = spi_mosi_oe_in;
		end
		else if (cfg2[PFS_B_GPIO])
		begin
			st_next.pad_o[1]  = gpio_o_in[1];
			st_next.pad_oe[1] = gpio_oe_in[1];
		end
		// idle uart lines rest high so no false start bit is seen
		st_next.lin_rx   = cfg2[PFS_B_HI] ? pin_lvl[1] : 1'b1;
		st_next.std_rx   = cfg2[PFS_B_MID] ? pin_lvl[1] : 1'b1;
		st_next.cap_i[1] = cfg2[PFS_B_CAP] & pin_lvl[1];
		st_next.mosi     = cfg2[PFS_B_SPI] & pin_lvl[1];
		// ------------------------------------------------ pin 3
		st_next.pad_o[2]  = 1'b0;
		st_next.pad_oe[2] = 1'b0;
		unique case (owner3)
			PFS_OWN_LIN_TX:
			begin
				st_next.pad_o[2]  = lin_uart_tx_in;
				st_next.pad_oe[2] = 1'b1;
			end
			PFS_OWN_STD_TX:
			begin
				st_next.pad_o[2]  = std_uart_tx_in;
				st_next.pad_oe[2] = 1'b1;
			end
			PFS_OWN_CAP:
			begin
				st_next.pad_o[2]  = capcomp_o_in[2];
				st_next.pad_oe[2] = 1'b1;
			end
			PFS_OWN_GPIO:
			begin
				st_next.pad_o[2]  = gpio_o_in[2];
				st_next.pad_oe[2] = 1'b1;
			end
			default:
			begin
				st_next.pad_o[2]  = 1'b0;
				st_next.pad_oe[2] = 1'b0;
			end
		endcase
		st_next.cap_i[2] = cfg3[PFS_B_CAP] & pin_lvl[2];
		// slave select is active low: deselected reads high
		st_next.ss = cfg3[PFS_B_SPI] ? pin_lvl[2] : 1'b1;
		// ------------------------------------------------ common
		st_next.gpio_i = {cfg3[PFS_B_GPIO], cfg2[PFS_B_GPIO],
			cfg1[PFS_B_GPIO]} & pin_lvl;
		st_next.irq_a = |({cfg3[PFS_B_IRQA], cfg2[PFS_B_IRQA],
			cfg1[PFS_B_IRQA]} & pin_lvl);
		st_next.irq_b = |({cfg3[PFS_B_IRQB], cfg2[PFS_B_IRQB],
			cfg1[PFS_B_IRQB]} & pin_lvl);
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			st_reg        <= '0;
			st_reg.m_scl  <= 1'b1;
			st_reg.s_scl  <= 1'b1;
			st_reg.lin_rx <= 1'b1;
			st_reg.std_rx <= 1'b1;
			st_reg.ss     <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// ============================================================
	// outputs, all from flip-flops
	assign readdata_out        = st_reg.rdata;
	assign waitrequest_out     = !st_reg.ack;
	assign response_out        = st_reg.resp;
	assign pad_out             = st_reg.pad_o;
	assign pad_oe_out          = st_reg.pad_oe;
	assign analog_connect_out  = st_reg.an;
	assign i2c_master_scl_out  = st_reg.m_scl;
	assign i2c_slave_b_scl_out = st_reg.s_scl;
	assign capcomp_i_out       = st_reg.cap_i;
	assign spi_clk_out         = st_reg.sck;
	assign spi_mosi_out        = st_reg.mosi;
	assign spi_ss_out          = st_reg.ss;
	assign lin_uart_rx_out     = st_reg.lin_rx;
	assign std_uart_rx_out     = st_reg.std_rx;
	assign gpio_i_out          = st_reg.gpio_i;
	assign touch_en_out        = st_reg.touch;
	assign pin_irq_a_out       = st_reg.irq_a;
	assign pin_irq_b_out       = st_reg.irq_b;

	// ============================================================
	// checks
	touch3_gate_a: assert property (@(posedge clk_in)
		disable iff (rst_in) touch_en_out[2] ==
		$past(cfg3[PFS_B_TOUCH] & st_reg.pad_cfg[PFS_B_AN3]))
		else $error("touch 3 not gated by analog connect");
	touch1_gate_a: assert property (@(posedge clk_in)
		disable iff (rst_in) touch_en_out[0] ==
		$past(cfg1[PFS_B_TOUCH] & st_reg.pad_cfg[PFS_B_AN1]))
		else $error("touch 1 not gated by analog connect");
	irq_a_or_a: assert property (@(posedge clk_in)
		disable iff (rst_in) pin_irq_a_out ==
		$past(|({cfg3[1], cfg2[1], cfg1[1]} & pin_lvl)))
		else $error("interrupt a does not match selected pins");
	irq_b_or_a: assert property (@(posedge clk_in)
		disable iff (rst_in) pin_irq_b_out ==
		$past(|({cfg3[2], cfg2[2], cfg1[2]} & pin_lvl)))
		else $error("interrupt b does not match selected pins");
	irq_both_a: assert property (@(posedge clk_in)
		disable iff (rst_in) $past(cfg2[1] & cfg2[2] & pin_lvl[1])
		|-> pin_irq_a_out && pin_irq_b_out)
		else $error("one pin failed to feed both interrupts");
	lin_tx_prio_a: assert property (@(posedge clk_in)
		disable iff (rst_in) $past(cfg3[6]) |-> pad_oe_out[2] &&
		pad_out[2] == $past(lin_uart_tx_in))
		else $error("lin tx not driving pin 3");
	std_tx_drive_a: assert property (@(posedge clk_in)
		disable iff (rst_in) $past(cfg3[5] & !cfg3[6]) |->
		pad_oe_out[2] && pad_out[2] == $past(std_uart_tx_in))
		else $error("std tx not driving pin 3");
	scl_open_drain_a: assert property (@(posedge clk_in)
		disable iff (rst_in) $past(cfg1[6] | cfg1[5]) |->
		pad_out[0] == 1'b0)
		else $error("scl pin driven high");
	lin_rx_route_a: assert property (@(posedge clk_in)
		disable iff (rst_in) $past(cfg2[6]) |->
		lin_uart_rx_out == $past(pin_lvl[1]))
		else $error("lin rx not routed from pin 2");
	bus_answer_a: assert property (@(posedge clk_in)
		disable iff (rst_in) (read_in | write_in) && waitrequest_out
		|=> !waitrequest_out)
		else $error("bus answer not after one wait cycle");
endmodule

/* File: test/pfs_periph_model.sv */
// pad buffers and peripheral lines facing the pin function select block
`timescale 1ns/1ps
module pfs_periph_model
(
	input  wire logic        clk_in,        // system clock
	input  wire logic        step_in,       // load new line values
	input  wire logic [22:0] rnd_in,        // values to load
	input  wire logic [2:0]  pad_drive_in,  // block drive level
	input  wire logic [2:0]  pad_oe_in,     // block drive enable
	output logic      [2:0]  pad_level_out, // wire level at pins
	output logic      [22:0] lines_out      // peripheral lines
);
	logic [22:0] lines_reg = 23'h00_0000;

	// ============================================================
	// peripherals change their lines only when told, then hold
	always @(posedge clk_in)
		if (step_in)
			lines_reg <= rnd_in;
	assign lines_out = lines_reg;

	// ============================================================
	// a released pad shows the outside level, not the last drive
	assign pad_level_out = (pad_oe_in & pad_drive_in) |
		(~pad_oe_in & lines_reg[22:20]);
endmodule

/* File: test/port0_pin_function_select_tb_top.sv */
// self-checking bench of the pin function select block
`timescale 1ns/1ps
module port0_pin_function_select_tb_top;
	import pfs_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [17:0] address = 18'h0_0000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] be = 4'h0;
	logic [31:0] readdata_out;
	logic waitrequest_out;
	logic [1:0] response_out;
	logic [2:0] pad_in, pad_out, pad_oe_out, analog_connect_out;
	logic i2c_master_scl_out, i2c_slave_b_scl_out;
	logic [2:0] capcomp_i_out, gpio_i_out, touch_en_out;
	logic spi_clk_out, spi_mosi_out, spi_ss_out;
	logic lin_uart_rx_out, std_uart_rx_out, pin_irq_a_out, pin_irq_b_out;
	logic step = 1'b0;
	logic [22:0] rnd = 23'h00_0000;
	logic [22:0] ln;
	logic [17:0] ra [4];
	int mreg [4];
	int failures = 0;
	int comparisons = 0;
	int seed = 14;
	logic [31:0] rd;
	logic [1:0] rs;

	initial
	begin
		forever #2.5 clk_in = ~clk_in;
	end

	pfs_top u_pfs_top (.clk_in(clk_in), .rst_in(rst_in),
		.address_in(address), .read_in(read), .write_in(write),
		.writedata_in(wdata), .byteenable_in(be),
		.readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
		.response_out(response_out), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_out(pad_oe_out), .analog_connect_out(analog_connect_out),
		.i2c_master_scl_in(ln[0]), .i2c_slave_b_scl_in(ln[1]),
		.i2c_master_scl_out(i2c_master_scl_out),
		.i2c_slave_b_scl_out(i2c_slave_b_scl_out),
		.capcomp_o_in(ln[4:2]), .capcomp_oe_in(ln[7:5]),
		.capcomp_i_out(capcomp_i_out), .spi_clk_o_in(ln[8]),
		.spi_clk_oe_in(ln[9]), .spi_clk_out(spi_clk_out),
		.spi_mosi_o_in(ln[10]), .spi_mosi_oe_in(ln[11]),
		.spi_mosi_out(spi_mosi_out), .spi_ss_out(spi_ss_out),
		.lin_uart_rx_out(lin_uart_rx_out), .std_uart_rx_out(std_uart_rx_out),
		.lin_uart_tx_in(ln[12]), .std_uart_tx_in(ln[13]),
		.gpio_o_in(ln[16:14]), .gpio_oe_in(ln[19:17]),
		.gpio_i_out(gpio_i_out), .touch_en_out(touch_en_out),
		.pin_irq_a_out(pin_irq_a_out), .pin_irq_b_out(pin_irq_b_out));

	pfs_periph_model u_pfs_periph_model (.clk_in(clk_in), .step_in(step),
		.rnd_in(rnd), .pad_drive_in(pad_out), .pad_oe_in(pad_oe_out),
		.pad_level_out(pad_in), .lines_out(ln));

	// ============================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [17:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk_in);
		address <= a;
		write <= wr;
		read <= ~wr;
		wdata <= d;
		be <= b;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (waitrequest_out !== 1'b0 && n < 50);
		if (n >= 50)
			failures++;
		rd = readdata_out;
		rs = response_out;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic end_of_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ============================================================
	// expected pin behaviour from the register model and the lines
	task automatic check_pins();
		logic [7:0] c0, c1, c2;
		logic [2:0] oe, dv, w, g;
		c0 = mreg[0][7:0];
		c1 = mreg[1][7:0];
		c2 = mreg[2][7:0];
		// pins 1 and 2 go to the highest selected function,
		// even while that function keeps its own driver off
		oe[0] = (c0[6] | c0[5]) ? ((c0[6] & ~ln[0]) | (c0[5] & ~ln[1])) :
			c0[4] ? ln[5] : c0[3] ? ln[9] : (c0[0] & ln[17]);
		dv[0] = (c0[6] | c0[5]) ? 1'b0 : c0[4] ? ln[2] :
			c0[3] ? ln[8] : ln[14];
		oe[1] = c1[4] ? ln[6] : c1[3] ? ln[11] : (c1[0] & ln[18]);
		dv[1] = c1[4] ? ln[3] : c1[3] ? ln[10] : ln[15];
		oe[2] = c2[6] | c2[5] | (c2[4] & ln[7]) | (c2[0] & ln[19]);
		dv[2] = c2[6] ? ln[12] : c2[5] ? ln[13] :
			(c2[4] & ln[7]) ? ln[4] : ln[16];
		w = (oe & dv) | (~oe & ln[22:20]);
		g = {c2[0], c1[0], c0[0]};
		check(pad_oe_out, oe);
		check(pad_out & oe, dv & oe);
		check(i2c_master_scl_out, c0[6] ? w[0] : 1'b1);
		check(i2c_slave_b_scl_out, c0[5] ? w[0] : 1'b1);
		check(capcomp_i_out, {c2[4], c1[4], c0[4]} & w);
		check(spi_clk_out, c0[3] & w[0]);
		check(spi_mosi_out, c1[3] & w[1]);
		check(spi_ss_out, c2[3] ? w[2] : 1'b1);
		check(lin_uart_rx_out, c1[6] ? w[1] : 1'b1);
		check(std_uart_rx_out, c1[5] ? w[1] : 1'b1);
		check(touch_en_out, {c2[7] & mreg[3][1], c1[7],
			c0[7] & mreg[3][0]});
		check(analog_connect_out, {mreg[3][1], 1'b0, mreg[3][0]});
		check(pin_irq_a_out, |({c2[1], c1[1], c0[1]} & w));
		check(pin_irq_b_out, |({c2[2], c1[2], c0[2]} & w));
		check(gpio_i_out, w & g);
	endtask

	// ============================================================
	// main sequence
	initial
	begin
		for (int i = 0; i < 4; i++)
			ra[i] = {(i == 3) ? PFS_PAD_IDX : PFS_PIN1_IDX + 16'(i), 2'h0};
		mreg = '{0, 0, 0, 0};
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, ra[i], 32'h0000_0000, 4'hf);
			check(rd, 32'h0000_0000);
		end
		check(pad_oe_out, 3'h0);
		check_pins();
		$display("test reset done");
		bus(1'b1, ra[0], 32'h0000_00ff, 4'h0);
		bus(1'b1, ra[0] + 18'h0_0001, 32'h0000_00ff, 4'hf);
		check(rs, 2'h2);
		bus(1'b0, 18'h0_0000, 32'h0000_0000, 4'hf);
		check(rs, 2'h2);
		check(rd, 32'h0000_0000);
		bus(1'b0, ra[0], 32'h0000_0000, 4'hf);
		check(rd, 32'h0000_0000);
		$display("test refusal done");
		repeat (120)
		begin
			for (int i = 0; i < 4; i++)
			begin
				rd = $random(seed);
				mreg[i] = (i == 3) ? int'(rd[1:0]) : int'(rd[7:0]);
				bus(1'b1, ra[i], rd, 4'hf);
				check(rs, 2'h0);
			end
			rnd <= 23'($random(seed));
			step <= 1'b1;
			@(posedge clk_in);
			step <= 1'b0;
			repeat (8) @(posedge clk_in);
			check_pins();
			for (int i = 0; i < 4; i++)
			begin
				bus(1'b0, ra[i], 32'h0000_0000, 4'hf);
				check(rd, 32'(mreg[i]));
			end
		end
		$display("test random functions done");
		// reset in mid-run must deselect every function again
		mreg = '{0, 0, 0, 0};
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		check_pins();
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b0, ra[i], 32'h0000_0000, 4'hf);
			check(rd, 32'h0000_0000);
		end
		$display("test mid-run reset done");
		end_of_test();
	end

	initial
	begin
		repeat (20000) @(posedge clk_in);
		failures++;
		end_of_test();
	end
endmodule
